/* File: fer_pkg.sv */
// Behaviour
// - single class selected: events for that class
// - class pair selected: events for either class
// - all selected: event for every frame
// - each event is one 64-bit packet
// - frame id in packet bits 15:0
// - overflow mask in packet bits 47:32
// - event carries type, frame number, timestamp
// - area scan takes id from camera stream
// - frame id is 16 bits, wraps to zero
// - line scan reports grabber-made frame id
// - truncated frame was shortened, still transferred
// - lost frame discarded, no transfer at all
// - never truncated and lost together
// - overload entry stops running frame, truncated
// - overload persists: arriving frames lost until leave
package fer_pkg;

	////////////////////////////////////////////////////////////////////////
	// event packet layout
	localparam int ID_W       = 16;
	localparam int PKT_W      = 64;
	localparam int MASK_LSB   = 32;
	localparam int MASK_W     = 16;
	localparam int CLS_W      = 3;
	localparam int MASK_TRUNC = 0;
	localparam int MASK_DROP  = 1;
	localparam int MASK_WHOLE = 2;

	////////////////////////////////////////////////////////////////////////
	// class filter selector
	typedef enum logic [2:0] {
		FILT_TRUNC          = 3'b000,
		FILT_DROP           = 3'b001,
		FILT_TRUNC_OR_DROP  = 3'b010,
		FILT_GOOD           = 3'b011,
		FILT_TRUNC_OR_GOOD  = 3'b100,
		FILT_DROP_OR_GOOD   = 3'b101,
		FILT_ALL            = 3'b110
	} fer_filter_t;

	////////////////////////////////////////////////////////////////////////
	// frame tracker states
	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_PASS = 2'b01,
		FR_CUT  = 2'b10,
		FR_DROP = 2'b11
	} fer_frame_t;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int         ADR_W          = 8;
	localparam logic [7:0] ADR_CTRL       = 8'h00;
	localparam logic [7:0] ADR_LEVELS     = 8'h04;
	localparam logic [7:0] ADR_STATE      = 8'h08;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ADR_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] ADR_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ADR_COUNTS     = 8'h18;

	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_LINE_BIT   = 1;
	localparam int CTRL_FILT_LSB   = 4;
	localparam int LVL_ENTER_LSB   = 0;
	localparam int LVL_LEAVE_LSB   = 8;
	localparam int LVL_W           = 8;
	localparam int ST_OVERLOAD_BIT = 0;
	localparam int ST_INFRAME_BIT  = 1;
	localparam int ST_PENDING_BIT  = 2;
	localparam int ST_ID_LSB       = 16;
	localparam int CNT_W           = 16;
	localparam int CNT_DROP_LSB    = 16;

	// levels held in half-percent steps
	localparam logic [7:0] ENTER_LEVEL_RST = 8'hC7;
	localparam logic [7:0] LEAVE_LEVEL_RST = 8'h64;
	localparam logic       ENABLE_RST      = 1'b1;
	localparam logic       LINE_RST        = 1'b0;

	localparam int IRQ_EVENT    = 0;
	localparam int IRQ_OVERLOAD = 1;
	localparam int IRQ_OVERRUN  = 2;
	localparam int IRQ_W        = 3;

	localparam int OCC_W = 7;

endpackage

/* File: fer_frame_counter.sv */
`timescale 1ns/1ps
module fer_frame_counter #(
	parameter int W = 16
) (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         en_i,
	input  wire logic         inc_i,
	output logic      [W-1:0] cnt_o
);

	if (W < 1) begin : g_chk
		$error("fer_frame_counter: W must be at least 1");
	end

	logic [W-1:0] cnt_reg;

	// wraps to zero past its maximum
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
		end else if (en_i && inc_i) begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end

	assign cnt_o = cnt_reg;

endmodule

/* File: fer_event_slot.sv */
`timescale 1ns/1ps
module fer_event_slot #(
	parameter int W = 96
) (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         en_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] data_i,
	output logic              accept_o,
	output logic              valid_o,
	input  wire logic         ready_i,
	output logic      [W-1:0] data_o
);

	if (W < 1) begin : g_chk
		$error("fer_event_slot: W must be at least 1");
	end

	logic         valid_reg;
	logic [W-1:0] data_reg;

	// room when empty or being drained this cycle
	assign accept_o = !valid_reg || ready_i;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			valid_reg <= 1'b0;
		end else if (en_i) begin
			if (load_i && accept_o) begin
				valid_reg <= 1'b1;
			end else if (ready_i) begin
				valid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data_reg <= '0;
		end else if (en_i && load_i && accept_o) begin
			data_reg <= data_i;
		end
	end

	assign valid_o = valid_reg;
	assign data_o  = data_reg;

endmodule

/* File: fer_frame_overflow_event_reporter.sv */
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module fer_frame_overflow_event_reporter #(
	parameter int TS_W = 32
) (
	input  wire logic                             mclk_i,
	input  wire logic                             sys_rst_i,
	input  wire logic                             ce_i,
	input  wire logic                             wb_cyc_i,
	input  wire logic                             wb_stb_i,
	input  wire logic                             wb_we_i,
	input  wire logic [fer_pkg::ADR_W-1:0]        wb_adr_i,
	input  wire logic [3:0]                       wb_sel_i,
	input  wire logic [31:0]                      wb_dat_i,
	output logic      [31:0]                      wb_dat_o,
	output logic                                  wb_ack_o,
	input  wire logic                             frame_start_i,
	input  wire logic                             frame_end_i,
	input  wire logic [fer_pkg::ID_W-1:0]         cam_frame_id_i,
	input  wire logic [fer_pkg::OCC_W-1:0]        buffer_occupancy_pct_i,
	output logic                                  frame_cut_o,
	output logic                                  overload_o,
	output logic                                  event_valid_o,
	input  wire logic                             event_ready_i,
	output logic      [fer_pkg::PKT_W-1:0]        event_data_o,
	output logic      [TS_W-1:0]                  event_ts_o,
	output logic                                  irq_o
);

	if (TS_W < 1 || TS_W > 64) begin : g_chk
		$error("fer_frame_overflow_event_reporter: TS_W must be 1..64");
	end

	localparam int SLOT_W = fer_pkg::PKT_W + TS_W;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic                         ack_reg;
	logic [31:0]                  rd_data_reg;
	logic [31:0]                  rd_data_next;
	logic                         wr_fire;
	logic                         enable_reg;
	logic                         line_scan_reg;
	fer_pkg::fer_filter_t         event_class_filter;
	logic [fer_pkg::LVL_W-1:0]    enter_overload_level;
	logic [fer_pkg::LVL_W-1:0]    leave_overload_level;
	logic [fer_pkg::IRQ_W-1:0]    irq_status_reg;
	logic [fer_pkg::IRQ_W-1:0]    irq_enable_reg;
	logic [fer_pkg::IRQ_W-1:0]    irq_set;
	logic [fer_pkg::IRQ_W-1:0]    irq_clr;
	logic                         overload_reg;
	logic                         overload_next;
	logic [fer_pkg::LVL_W-1:0]    occ_half;
	fer_pkg::fer_frame_t          frame_reg;
	fer_pkg::fer_frame_t          frame_next;
	logic [fer_pkg::ID_W-1:0]     grab_id;
	logic [fer_pkg::ID_W-1:0]     frame_id_reg;
	logic [fer_pkg::ID_W-1:0]     last_id_reg;
	logic [TS_W-1:0]              ts_reg;
	logic [TS_W-1:0]              frame_ts_reg;
	logic                         frame_close;
	logic                         frame_open;
	logic [31:0]                  irq_en_word;
	logic [fer_pkg::CLS_W-1:0]    cls;
	logic [fer_pkg::CLS_W-1:0]    cls_enabled;
	logic                         emit;
	logic [fer_pkg::PKT_W-1:0]    pkt;
	logic                         slot_accept;
	logic [SLOT_W-1:0]            slot_out;
	logic [fer_pkg::CNT_W-1:0]    trunc_cnt_reg;
	logic [fer_pkg::CNT_W-1:0]    drop_cnt_reg;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// classes passed by each selector setting
	function automatic logic [fer_pkg::CLS_W-1:0] filter_mask(input fer_pkg::fer_filter_t f);
		logic [fer_pkg::CLS_W-1:0] m;
		m = '0;
		case (f)
			fer_pkg::FILT_TRUNC: begin
				m[fer_pkg::MASK_TRUNC] = 1'b1;
			end
			fer_pkg::FILT_DROP: begin
				m[fer_pkg::MASK_DROP] = 1'b1;
			end
			fer_pkg::FILT_GOOD: begin
				m[fer_pkg::MASK_WHOLE] = 1'b1;
			end
			fer_pkg::FILT_TRUNC_OR_DROP: begin
				m[fer_pkg::MASK_TRUNC] = 1'b1;
				m[fer_pkg::MASK_DROP]  = 1'b1;
			end
			fer_pkg::FILT_TRUNC_OR_GOOD: begin
				m[fer_pkg::MASK_TRUNC] = 1'b1;
				m[fer_pkg::MASK_WHOLE] = 1'b1;
			end
			fer_pkg::FILT_DROP_OR_GOOD: begin
				m[fer_pkg::MASK_DROP]  = 1'b1;
				m[fer_pkg::MASK_WHOLE] = 1'b1;
			end
			fer_pkg::FILT_ALL: begin
				m = '1;
			end
			default: begin
				m = '0;
			end
		endcase
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// wishbone slave, one wait state
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_reg <= 1'b0;
		end else if (ce_i) begin
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
		end
	end

	always_comb begin
		rd_data_next = '0;
		case (wb_adr_i)
			fer_pkg::ADR_CTRL: begin
				rd_data_next[fer_pkg::CTRL_ENABLE_BIT] = enable_reg;
				rd_data_next[fer_pkg::CTRL_LINE_BIT]   = line_scan_reg;
				rd_data_next[fer_pkg::CTRL_FILT_LSB +: 3] = event_class_filter;
			end
			fer_pkg::ADR_LEVELS: begin
				rd_data_next[fer_pkg::LVL_ENTER_LSB +: fer_pkg::LVL_W] = enter_overload_level;
				rd_data_next[fer_pkg::LVL_LEAVE_LSB +: fer_pkg::LVL_W] = leave_overload_level;
			end
			fer_pkg::ADR_STATE: begin
				rd_data_next[fer_pkg::ST_OVERLOAD_BIT] = overload_reg;
				rd_data_next[fer_pkg::ST_INFRAME_BIT]  = frame_reg != fer_pkg::FR_IDLE;
				rd_data_next[fer_pkg::ST_PENDING_BIT]  = event_valid_o;
				rd_data_next[fer_pkg::ST_ID_LSB +: fer_pkg::ID_W] = last_id_reg;
			end
			fer_pkg::ADR_IRQ_STATUS: begin
				rd_data_next[fer_pkg::IRQ_W-1:0] = irq_status_reg;
			end
			fer_pkg::ADR_IRQ_ENABLE: begin
				rd_data_next[fer_pkg::IRQ_W-1:0] = irq_enable_reg;
			end
			fer_pkg::ADR_COUNTS: begin
				rd_data_next[0 +: fer_pkg::CNT_W] = trunc_cnt_reg;
				rd_data_next[fer_pkg::CNT_DROP_LSB +: fer_pkg::CNT_W] = drop_cnt_reg;
			end
			default: begin
				rd_data_next = '0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_reg <= '0;
		end else if (ce_i) begin
			rd_data_reg <= (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) ? rd_data_next : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rd_data_reg;

	////////////////////////////////////////////////////////////////////////
	// software settings
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			enable_reg         <= fer_pkg::ENABLE_RST;
			line_scan_reg      <= fer_pkg::LINE_RST;
			event_class_filter <= fer_pkg::FILT_TRUNC_OR_DROP;
		end else if (ce_i && wr_fire && wb_adr_i == fer_pkg::ADR_CTRL && wb_sel_i[0]) begin
			enable_reg         <= wb_dat_i[fer_pkg::CTRL_ENABLE_BIT];
			line_scan_reg      <= wb_dat_i[fer_pkg::CTRL_LINE_BIT];
			event_class_filter <= fer_pkg::fer_filter_t'(wb_dat_i[fer_pkg::CTRL_FILT_LSB +: 3]);
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			enter_overload_level <= fer_pkg::ENTER_LEVEL_RST;
			leave_overload_level <= fer_pkg::LEAVE_LEVEL_RST;
		end else if (ce_i && wr_fire && wb_adr_i == fer_pkg::ADR_LEVELS) begin
			if (wb_sel_i[0]) begin
				enter_overload_level <= wb_dat_i[fer_pkg::LVL_ENTER_LSB +: fer_pkg::LVL_W];
			end
			if (wb_sel_i[1]) begin
				leave_overload_level <= wb_dat_i[fer_pkg::LVL_LEAVE_LSB +: fer_pkg::LVL_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overload hysteresis
	assign occ_half = {buffer_occupancy_pct_i, 1'b0};

	always_comb begin
		if (!enable_reg) begin
			overload_next = 1'b0;
		end else if (!overload_reg) begin
			overload_next = occ_half > enter_overload_level;
		end else begin
			overload_next = !(occ_half < leave_overload_level);
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overload_reg <= 1'b0;
		end else if (ce_i) begin
			overload_reg <= overload_next;
		end
	end

	assign overload_o = overload_reg;

	////////////////////////////////////////////////////////////////////////
	// frame tracking and classification
	assign frame_close = frame_end_i && frame_reg != fer_pkg::FR_IDLE;
	// accepted start: from idle, or back to back with an end
	assign frame_open  = frame_start_i && enable_reg && (frame_reg == fer_pkg::FR_IDLE || frame_end_i);

	always_comb begin
		frame_next = frame_reg;
		case (frame_reg)
			fer_pkg::FR_IDLE: begin
				if (frame_start_i && enable_reg) begin
					frame_next = overload_next ? fer_pkg::FR_DROP : fer_pkg::FR_PASS;
				end
			end
			fer_pkg::FR_PASS: begin
				if (frame_end_i) begin
					frame_next = fer_pkg::FR_IDLE;
				end else if (overload_next) begin
					frame_next = fer_pkg::FR_CUT;
				end
			end
			fer_pkg::FR_CUT, fer_pkg::FR_DROP: begin
				if (frame_end_i) begin
					frame_next = fer_pkg::FR_IDLE;
				end
			end
			default: begin
				frame_next = fer_pkg::FR_IDLE;
			end
		endcase
		// back-to-back frames: end and next start in one cycle
		if (frame_close && frame_start_i && enable_reg) begin
			frame_next = overload_next ? fer_pkg::FR_DROP : fer_pkg::FR_PASS;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_reg <= fer_pkg::FR_IDLE;
		end else if (ce_i) begin
			frame_reg <= frame_next;
		end
	end

	// stops the data path for truncated and lost frames
	assign frame_cut_o = frame_reg == fer_pkg::FR_CUT || frame_reg == fer_pkg::FR_DROP;

	fer_frame_counter #(
		.W (fer_pkg::ID_W)
	) u_grab_id (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (ce_i),
		.inc_i     (frame_open),
		.cnt_o     (grab_id)
	);

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ts_reg <= '0;
		end else if (ce_i) begin
			ts_reg <= ts_reg + TS_W'(1);
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_id_reg <= '0;
			frame_ts_reg <= '0;
		end else if (ce_i && frame_open) begin
			frame_id_reg <= line_scan_reg ? grab_id : cam_frame_id_i;
			frame_ts_reg <= ts_reg;
		end
	end

	// exactly one class bit per closed frame
	always_comb begin
		cls = '0;
		case (frame_reg)
			fer_pkg::FR_CUT: begin
				cls[fer_pkg::MASK_TRUNC] = 1'b1;
			end
			fer_pkg::FR_DROP: begin
				cls[fer_pkg::MASK_DROP] = 1'b1;
			end
			fer_pkg::FR_PASS: begin
				cls[fer_pkg::MASK_WHOLE] = 1'b1;
			end
			default: begin
				cls = '0;
			end
		endcase
	end

	assign cls_enabled = cls & filter_mask(event_class_filter);
	assign emit        = frame_close && (cls_enabled != '0);

	always_comb begin
		pkt = '0;
		pkt[fer_pkg::ID_W-1:0] = frame_id_reg;
		pkt[fer_pkg::MASK_LSB +: fer_pkg::CLS_W] = cls;
	end

	fer_event_slot #(
		.W (SLOT_W)
	) u_slot (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (ce_i),
		.load_i    (emit),
		.data_i    ({frame_ts_reg, pkt}),
		.accept_o  (slot_accept),
		.valid_o   (event_valid_o),
		.ready_i   (event_ready_i),
		.data_o    (slot_out)
	);

	assign event_data_o = slot_out[fer_pkg::PKT_W-1:0];
	assign event_ts_o   = slot_out[SLOT_W-1:fer_pkg::PKT_W];

	////////////////////////////////////////////////////////////////////////
	// statistics
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trunc_cnt_reg <= '0;
			drop_cnt_reg  <= '0;
			last_id_reg   <= '0;
		end else if (ce_i && frame_close) begin
			last_id_reg <= frame_id_reg;
			if (cls[fer_pkg::MASK_TRUNC]) begin
				trunc_cnt_reg <= trunc_cnt_reg + fer_pkg::CNT_W'(1);
			end
			if (cls[fer_pkg::MASK_DROP]) begin
				drop_cnt_reg <= drop_cnt_reg + fer_pkg::CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts, set wins over clear
	always_comb begin
		irq_set = '0;
		irq_set[fer_pkg::IRQ_EVENT]    = emit && slot_accept;
		irq_set[fer_pkg::IRQ_OVERLOAD] = overload_next && !overload_reg;
		irq_set[fer_pkg::IRQ_OVERRUN]  = emit && !slot_accept;
		irq_clr = '0;
		if (wr_fire && wb_adr_i == fer_pkg::ADR_IRQ_CLEAR && wb_sel_i[0]) begin
			irq_clr = wb_dat_i[fer_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_status_reg <= '0;
		end else if (ce_i) begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_enable_reg <= '0;
		end else if (ce_i && wr_fire && wb_adr_i == fer_pkg::ADR_IRQ_ENABLE && wb_sel_i[0]) begin
			irq_enable_reg <= irq_en_word[fer_pkg::IRQ_W-1:0];
		end
	end

	assign irq_en_word = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);

	assign irq_o = |(irq_status_reg & irq_enable_reg);

endmodule

/* File: fer_properties.sv */
`timescale 1ns/1ps
module fer_properties #(
	parameter int TS_W = 32
) (
	input wire logic                      mclk_i,
	input wire logic                      sys_rst_i,
	input wire logic                      ce_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      frame_end_i,
	input wire logic                      frame_cut_o,
	input wire logic                      overload_o,
	input wire logic                      event_valid_o,
	input wire logic                      event_ready_i,
	input wire logic [fer_pkg::PKT_W-1:0] event_data_o,
	input wire logic [TS_W-1:0]           event_ts_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("request not acknowledged after one wait cycle");
	ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside acknowledge");
	pkt_zero_a: assert property (event_valid_o |-> event_data_o[31:16] == 16'h0 && event_data_o[63:35] == 29'h0)
		else $error("reserved packet bits not zero");
	one_class_a: assert property (event_valid_o |-> $onehot(event_data_o[34:32]))
		else $error("event class bits not exactly one");
	event_hold_a: assert property (event_valid_o && !event_ready_i && ce_i |=>
		event_valid_o && $stable(event_data_o) && $stable(event_ts_o))
		else $error("pending event changed before being taken");
	event_cause_a: assert property ($rose(event_valid_o) |-> $past(frame_end_i))
		else $error("event raised without a frame end");
	cut_cause_a: assert property ($rose(frame_cut_o) |-> overload_o)
		else $error("frame cut without overload state");
	event_release_a: assert property ($fell(event_valid_o) |-> $past(event_ready_i))
		else $error("event withdrawn without consumer ready");
endmodule

bind fer_frame_overflow_event_reporter fer_properties #(.TS_W(TS_W)) u_props (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_end_i(frame_end_i), .frame_cut_o(frame_cut_o),
	.overload_o(overload_o), .event_valid_o(event_valid_o), .event_ready_i(event_ready_i),
	.event_data_o(event_data_o), .event_ts_o(event_ts_o)
);

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	logic        mclk_i                 = 1'b0;
	logic        sys_rst_i              = 1'b1;
	logic        wb_cyc_i               = 1'b0;
	logic        wb_stb_i               = 1'b0;
	logic        wb_we_i                = 1'b0;
	logic [7:0]  wb_adr_i               = 8'h00;
	logic [3:0]  wb_sel_i               = 4'h0;
	logic [31:0] wb_dat_i               = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        frame_start_i          = 1'b0;
	logic        frame_end_i            = 1'b0;
	logic [15:0] cam_frame_id_i         = 16'h0;
	logic [6:0]  buffer_occupancy_pct_i = 7'h00;
	logic        frame_cut_o;
	logic        overload_o;
	logic        event_valid_o;
	logic        event_ready_i          = 1'b0;
	logic [63:0] event_data_o;
	logic [31:0] event_ts_o;
	logic        irq_o;
	int          error_cnt              = 0;
	int          samples_checked        = 0;
	logic [2:0]  fmask [0:6]            = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
	logic [15:0] id;
	logic        hit;
	logic        ce_i                   = 1'b1;
	logic [31:0] cycle_no               = 32'h0;
	logic [31:0] start_ts;
	logic [31:0] ts_first;

	always #2 mclk_i = ~mclk_i;

	// reference timestamp: running clock-enabled cycles since reset
	always @(posedge mclk_i) begin
		if (!sys_rst_i && ce_i) begin
			cycle_no <= cycle_no + 32'h1;
		end
	end

	fer_frame_overflow_event_reporter #(.TS_W(32)) dut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .frame_start_i(frame_start_i), .frame_end_i(frame_end_i),
		.cam_frame_id_i(cam_frame_id_i), .buffer_occupancy_pct_i(buffer_occupancy_pct_i),
		.frame_cut_o(frame_cut_o), .overload_o(overload_o), .event_valid_o(event_valid_o),
		.event_ready_i(event_ready_i), .event_data_o(event_data_o), .event_ts_o(event_ts_o), .irq_o(irq_o)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_evt(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	// classic cycle: hold until ack is seen at an edge
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] unused;
		wb_io(1'b1, adr, d, unused);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] v;
		wb_io(1'b0, adr, 32'h0, v);
		chk_reg(v, exp);
	endtask

	// class 0 truncated, 1 lost, 2 complete
	task automatic frame(input logic [15:0] fid, input int cls);
		buffer_occupancy_pct_i <= (cls == 1) ? 7'h64 : 7'h00;
		tick(3);
		frame_start_i  <= 1'b1;
		cam_frame_id_i <= fid;
		tick(1);
		start_ts = cycle_no;
		frame_start_i <= 1'b0;
		if (cls == 0) begin
			buffer_occupancy_pct_i <= 7'h64;
		end
		tick(3);
		chk_reg({30'h0, frame_cut_o, overload_o}, (cls == 2) ? 32'h0 : 32'h3);
		frame_end_i <= 1'b1;
		tick(1);
		frame_end_i            <= 1'b0;
		buffer_occupancy_pct_i <= 7'h00;
		tick(4);
	endtask

	task automatic evt_chk(input logic present, input logic [63:0] exp, input logic [31:0] ts);
		chk_reg({31'h0, event_valid_o}, {31'h0, present});
		if (present) begin
			chk_evt(event_data_o, exp);
			chk_reg(event_ts_o, ts);
			event_ready_i <= 1'b1;
			tick(1);
			event_ready_i <= 1'b0;
			tick(1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		sys_rst_i <= 1'b0;
		tick(1);
		rd_chk(fer_pkg::ADR_CTRL, 32'h21);
		rd_chk(fer_pkg::ADR_LEVELS, 32'h64C7);
		rd_chk(fer_pkg::ADR_IRQ_ENABLE, 32'h0);
		rd_chk(8'h1C, 32'h0);
		wr(fer_pkg::ADR_COUNTS, 32'hFFFFFFFF);
		wr(fer_pkg::ADR_IRQ_ENABLE, 32'h1);
		for (int f = 0; f < 7; f++) begin
			wr(fer_pkg::ADR_CTRL, {25'h0, 3'(f), 4'h1});
			for (int c = 0; c < 3; c++) begin
				id  = 16'hFFF0 + 16'(f * 3 + c);
				hit = fmask[f][c];
				frame(id, c);
				evt_chk(hit, {29'h0, 3'(1 << c), 16'h0, id}, start_ts);
				chk_reg({31'h0, irq_o}, {31'h0, hit});
				wr(fer_pkg::ADR_IRQ_CLEAR, 32'h7);
				tick(1);
				chk_reg({31'h0, irq_o}, 32'h0);
			end
		end
		rd_chk(fer_pkg::ADR_COUNTS, 32'h00070007);
		// masked interrupt and overrun of the single event slot
		wr(fer_pkg::ADR_IRQ_ENABLE, 32'h0);
		wr(fer_pkg::ADR_CTRL, 32'h61);
		frame(16'h1234, 2);
		ts_first = start_ts;
		frame(16'h5678, 2);
		rd_chk(fer_pkg::ADR_IRQ_STATUS, 32'h5);
		chk_reg({31'h0, irq_o}, 32'h0);
		evt_chk(1'b1, {29'h0, 3'b100, 16'h0, 16'h1234}, ts_first);
		wr(fer_pkg::ADR_IRQ_CLEAR, 32'h7);
		rd_chk(fer_pkg::ADR_IRQ_STATUS, 32'h0);
		// frame start while clock enable is low must be ignored
		ce_i           <= 1'b0;
		frame_start_i  <= 1'b1;
		cam_frame_id_i <= 16'h9999;
		tick(2);
		frame_start_i <= 1'b0;
		tick(1);
		ce_i <= 1'b1;
		rd_chk(fer_pkg::ADR_STATE, 32'h5678_0000);
		// line scan: id from the grabber count of accepted starts (23 so far)
		wr(fer_pkg::ADR_CTRL, 32'h63);
		frame(16'hABCD, 2);
		evt_chk(1'b1, {29'h0, 3'b100, 16'h0, 16'h0017}, start_ts);
		tally_and_finish();
	end
endmodule
